// >>> rtl/cfr_defs.svh
// Constants of the coordinator fault register block.
// Assumes a 100 MHz system clock; included by the package and modules.
`ifndef CFR_DEFS_SVH
`define CFR_DEFS_SVH

`define CFR_CPU_COUNT        4
`define CFR_DATA_W           8
`define CFR_ADDR_W           20
`define CFR_COUNT_W          18
`define CFR_ADDR_SHARED16    16'hFEFF
`define CFR_ADDR_SHARED20    20'hFFEFF
`define CFR_FAULT_RESET      8'h00
`define CFR_PAGE_RESET       8'h00
`define CFR_PAGE_FIRST       8'hFC
`define CFR_PAGE_LAST        8'hFF
`define CFR_CLK_HZ           100000000
`define CFR_CLK_NS           10
`define CFR_LOCK_LIMIT_MS    2
`define CFR_LOCK_CYCLES      (`CFR_LOCK_LIMIT_MS * (`CFR_CLK_HZ / 1000))
`define CFR_BIT_RATE_BPS     9600
`define CFR_BIT_CYCLES       (`CFR_CLK_HZ / `CFR_BIT_RATE_BPS)
`define CFR_ACK_MAX_NS       320
`define CFR_ACK_MAX_CYCLES   (`CFR_ACK_MAX_NS / `CFR_CLK_NS)

`endif

// >>> rtl/cfr_pkg.sv
// Types shared by the coordinator fault register block.
// Assumes cfr_defs.svh is on the include path.
`include "cfr_defs.svh"

package cfr_pkg;

    typedef struct packed {
        logic [`CFR_ADDR_W-1:0] addr;     // Backplane address
        logic                   extended; // 20-bit address form in use
        logic                   read;     // Read strobe, active high
        logic                   write;    // Write strobe, active high
        logic [`CFR_DATA_W-1:0] wdata;    // Write data
    } cfr_bus_req_type;

    typedef struct packed {
        logic [`CFR_CPU_COUNT-1:0] request; // Bus request per CPU
        logic [`CFR_CPU_COUNT-1:0] lock;    // Bus lock per CPU
    } cfr_cpu_sig_type;

    typedef enum logic [1:0] {
        ARB_IDLE    = 2'b01,
        ARB_GRANTED = 2'b10
    } cfr_arb_state_type;

endpackage

// >>> rtl/cfr_timer.sv
// Cycle counter that flags when a run has lasted LIMIT cycles.
// Assumes one clock, active-low async reset and a global clock enable.
`timescale 1ns/1ns
`include "cfr_defs.svh"

module cfr_timer #(
    parameter int LIMIT = 16, // Cycles until done
    parameter bit WRAP  = 0   // Restart after each done
) (
    input  wire logic sys_clk, // System clock
    input  wire logic rst_b,   // Async reset, active low
    input  wire logic clkEn,   // Clock enable
    input  wire logic run,     // Count while high, clear while low
    output logic      done     // High in the last cycle of a period; held high after it while run stays high if WRAP is 0
);
    localparam logic [`CFR_COUNT_W-1:0] LAST = `CFR_COUNT_W'(LIMIT - 1);

    logic [`CFR_COUNT_W-1:0] count;
    logic [`CFR_COUNT_W-1:0] next_count;
    wire                     atLast = (count == LAST);

    assign done       = run && atLast;
    assign next_count = !run   ? '0 :
                        atLast ? (WRAP ? '0 : count) :
                        count + `CFR_COUNT_W'(1);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (clkEn) begin
            count <= next_count;
        end
    end
endmodule

// >>> rtl/cfr_top.sv
// Coordinator fault register, page select and bus arbitration.
// Assumes backplane strobes are synchronous to sys_clk and held until ack.
//
// Behaviour
// - Eight-bit fault register readable by any CPU at the shared address.
// - Only the bus monitor changes fault bits; CPU writes never do.
// - Each CPU owns one fault bit, set to one on its error.
// - Whole fault register clears when the stop signal goes inactive.
// - Every CPU may read the fault register, not only the culprit.
// - Writes load page select, reads return faults; 20-bit form too.
// - Open coordination jumpers disconnect every arbitration output.
// - Closed jumpers, the delivered state, enable coordination outputs.
// - Accesses are acknowledged well within 320 ns.
// - Programmer port bit clock runs at 9600 bps.
// - Lock held over 2 ms stops all CPUs and marks the culprit.
// - Page select is eight bits, write-only, never read back.
// - Page select clears to zero at power-up.
// - Page identifiers 252 to 255 select four one-kilobyte pages.
`timescale 1ns/1ns
`include "cfr_defs.svh"

module cfr_top #(
    parameter int LOCK_CYCLES = `CFR_LOCK_CYCLES, // Lock timeout in cycles
    parameter int BIT_CYCLES  = `CFR_BIT_CYCLES   // Programmer bit period
) (
    input  wire logic                      sys_clk,      // System clock
    input  wire logic                      rst_b,        // Power-on reset
    input  wire logic                      clkEn,        // Clock enable
    input  wire cfr_pkg::cfr_bus_req_type  busReq,       // Backplane access
    output logic [`CFR_DATA_W-1:0]         busRdata,     // Read data
    output logic                           busAck,       // Access ack pulse
    input  wire cfr_pkg::cfr_cpu_sig_type  cpuSig,       // Requests, locks
    input  wire logic                      jumperClosed, // Coordination on
    output logic [`CFR_CPU_COUNT-1:0]      busGrant,     // Bus enable per CPU
    output logic                           busGrantOe,   // Grant drive enable
    output logic                           systemStop,   // Stop all CPUs
    output logic                           systemStopOe, // Stop drive enable
    output logic [`CFR_DATA_W-1:0]         faultFlags,   // Fault bits, LEDs
    output logic                           pageActive,   // Own page selected
    output logic [1:0]                     pageIndex,    // Page 0..3
    output logic                           programmerPortBitTick // Bit tick
);
    localparam int CPUS = `CFR_CPU_COUNT;

    // Bus decode
    logic                   accessBusy;
    logic [`CFR_DATA_W-1:0] pageSelect;
    wire addrHit = busReq.extended
                   ? (busReq.addr == `CFR_ADDR_SHARED20)
                   : (busReq.addr[15:0] == `CFR_ADDR_SHARED16);
    wire strobe    = busReq.read || busReq.write;
    // One acceptance per strobe; the master holds strobes until acked
    wire accept    = strobe && addrHit && !accessBusy;
    wire takeWrite = accept && busReq.write;
    wire takeRead  = accept && busReq.read && !busReq.write;

    // Page select is write-only: its value only steers the page decode
    wire [`CFR_DATA_W-1:0] next_pageSelect =
        takeWrite ? busReq.wdata : pageSelect;
    wire next_pageActive =
        (next_pageSelect >= `CFR_PAGE_FIRST) &&
        (next_pageSelect <= `CFR_PAGE_LAST);
    wire [1:0] next_pageIndex = next_pageSelect[1:0];

    // Arbitration
    cfr_pkg::cfr_arb_state_type arbState;
    cfr_pkg::cfr_arb_state_type next_arbState;
    logic [1:0]                 owner;
    logic [1:0]                 next_owner;
    logic                       pickValid;
    logic [1:0]                 pickOwner;

    // Round robin: search starts just after the last owner
    always_comb begin
        logic [1:0] cand;
        cand      = owner;
        pickValid = 1'b0;
        pickOwner = owner;
        for (int i = 1; i <= CPUS; i++) begin
            cand = owner + 2'(i);
            if (!pickValid && cpuSig.request[cand]) begin
                pickValid = 1'b1;
                pickOwner = cand;
            end
        end
    end

    wire ownerLock = cpuSig.lock[owner];
    wire granted   = (arbState == cfr_pkg::ARB_GRANTED);
    // Lock extends the grant beyond the request
    wire release_  = granted && !cpuSig.request[owner] && !ownerLock;

    always_comb begin
        next_arbState = arbState;
        next_owner    = owner;
        unique case (arbState)
            cfr_pkg::ARB_IDLE: begin
                if (pickValid) begin
                    next_arbState = cfr_pkg::ARB_GRANTED;
                    next_owner    = pickOwner;
                end
            end
            cfr_pkg::ARB_GRANTED: begin
                if (release_) begin
                    next_arbState = cfr_pkg::ARB_IDLE;
                end
            end
            default: begin
                next_arbState = cfr_pkg::ARB_IDLE;
            end
        endcase
    end

    // Lock monitor: only the granted CPU may hold lock
    logic lockTimeout;
    wire  lockWatch = granted && ownerLock;

    cfr_timer #(
        .LIMIT (LOCK_CYCLES),
        .WRAP  (1'b0)
    ) u_lock_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clkEn   (clkEn),
        .run     (lockWatch),
        .done    (lockTimeout)
    );

    // Stop stays until the offending lock is released
    logic stopActive;
    wire  next_stopActive = stopActive ? lockWatch : lockTimeout;
    wire  stopFalls       = stopActive && !next_stopActive;
    wire  faultEvent      = lockTimeout && !stopActive;

    wire [`CFR_DATA_W-1:0] ownerBit = `CFR_DATA_W'(1) << owner;
    wire [`CFR_DATA_W-1:0] setBits  =
        faultEvent ? ownerBit : '0;
    // A set in the clearing cycle survives; CPU writes never reach here
    wire [`CFR_DATA_W-1:0] next_faultFlags =
        (stopFalls ? '0 : faultFlags) | setBits;

    // Jumpers cut every arbitration output when open
    wire [CPUS-1:0] next_busGrant =
        (jumperClosed && next_arbState == cfr_pkg::ARB_GRANTED)
        ? (CPUS'(1) << next_owner) : '0;
    wire next_stop = jumperClosed && next_stopActive;

    // Programmer port bit clock
    logic bitTick;

    cfr_timer #(
        .LIMIT (BIT_CYCLES),
        .WRAP  (1'b1)
    ) u_bit_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clkEn   (clkEn),
        .run     (1'b1),
        .done    (bitTick)
    );

    // Reads answer with faults only; page select is never returned
    wire [`CFR_DATA_W-1:0] next_busRdata =
        takeRead ? faultFlags : busRdata;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pageSelect <= `CFR_PAGE_RESET;
            pageActive <= 1'b0;
            pageIndex  <= 2'h0;
        end else if (clkEn) begin
            pageSelect <= next_pageSelect;
            pageActive <= next_pageActive;
            pageIndex  <= next_pageIndex;
        end
    end

    // Ack one cycle after acceptance, far inside the bus limit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            accessBusy <= 1'b0;
            busAck     <= 1'b0;
            busRdata   <= 8'h00;
        end else if (clkEn) begin
            accessBusy <= strobe && (accessBusy || addrHit);
            busAck     <= accept;
            busRdata   <= next_busRdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            arbState <= cfr_pkg::ARB_IDLE;
            owner    <= 2'h3;
            busGrant <= '0;
        end else if (clkEn) begin
            arbState <= next_arbState;
            owner    <= next_owner;
            busGrant <= next_busGrant;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stopActive   <= 1'b0;
            systemStop   <= 1'b0;
            busGrantOe   <= 1'b0;
            systemStopOe <= 1'b0;
            faultFlags   <= `CFR_FAULT_RESET;
        end else if (clkEn) begin
            stopActive   <= next_stopActive;
            systemStop   <= next_stop;
            busGrantOe   <= jumperClosed;
            systemStopOe <= jumperClosed;
            faultFlags   <= next_faultFlags;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            programmerPortBitTick <= 1'b0;
        end else if (clkEn) begin
            programmerPortBitTick <= bitTick;
        end
    end
endmodule

// >>> tb/cfr_top_assertions.sv
// Port checker for cfr_top, bound onto every instance.
// Assumes helper counters advance only on enabled edges, like the design.
`timescale 1ns/1ns
`include "cfr_defs.svh"
module cfr_top_checker #(
    parameter int LOCK_CYCLES = 20, // Lock timeout
    parameter int BIT_CYCLES  = 8   // Bit period
) (
    input wire logic                     sys_clk,      // Clock
    input wire logic                     rst_b,        // Reset
    input wire logic                     clkEn,        // Enable
    input wire cfr_pkg::cfr_bus_req_type busReq,       // Access
    input wire logic [`CFR_DATA_W-1:0]   busRdata,     // Read data
    input wire logic                     busAck,       // Ack
    input wire cfr_pkg::cfr_cpu_sig_type cpuSig,       // CPU lines
    input wire logic                     jumperClosed, // Jumpers
    input wire logic [`CFR_CPU_COUNT-1:0] busGrant,    // Grants
    input wire logic                     busGrantOe,   // Grant enable
    input wire logic                     systemStop,   // Stop
    input wire logic                     systemStopOe, // Stop enable
    input wire logic [`CFR_DATA_W-1:0]   faultFlags,   // Faults
    input wire logic                     pageActive,   // Page hit
    input wire logic [1:0]               pageIndex,    // Page
    input wire logic                     programmerPortBitTick // Tick
);
    cfr_pkg::cfr_bus_req_type reqPrev;
    logic [`CFR_COUNT_W-1:0]  lockCnt;
    logic [15:0]              tickGap;
    logic                     tickSeen;
    // The first tick has no known phase, so only later gaps are judged
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reqPrev  <= '0;
            lockCnt  <= '0;
            tickGap  <= '0;
            tickSeen <= 1'h0;
        end else if (clkEn) begin
            // Frozen edges must not age the gap or lock counts
            reqPrev  <= busReq;
            lockCnt  <= |(cpuSig.lock & busGrant) ? lockCnt + 1'h1 : '0;
            tickGap  <= programmerPortBitTick ? '0 : tickGap + 1'h1;
            tickSeen <= tickSeen | programmerPortBitTick;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_ack_single: assert property (busAck |=> !busAck)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (busAck |-> reqPrev.read || reqPrev.write)
        else $error("ack without access");
    a_read_flags: assert property (busAck && !reqPrev.write
        |-> busRdata == $past(faultFlags)) else $error("bad read data");
    a_write_page: assert property (busAck && reqPrev.write
        |-> pageIndex == reqPrev.wdata[1:0]
            && pageActive == (reqPrev.wdata >= 8'hFC))
        else $error("page select not loaded");
    a_flags_cause: assert property ($changed(faultFlags)
        |-> $changed(systemStop)) else $error("flags changed alone");
    a_stop_marks: assert property ($rose(systemStop)
        |-> (faultFlags[3:0] & busGrant) != 4'h0 && faultFlags[7:4] == 4'h0)
        else $error("stop without owner flag");
    a_stop_time: assert property ($rose(systemStop)
        |-> lockCnt >= LOCK_CYCLES - 1 && lockCnt <= LOCK_CYCLES + 1)
        else $error("lock timeout length wrong");
    a_stop_clear: assert property ($fell(systemStop)
        |-> faultFlags == 8'h00) else $error("flags not cleared");
    a_jumper_open: assert property (!$past(jumperClosed)
        |-> busGrant == 4'h0 && !busGrantOe && !systemStop && !systemStopOe)
        else $error("outputs driven with jumpers open");
    a_jumper_shut: assert property ($past(rst_b) && $past(jumperClosed)
        |-> busGrantOe && systemStopOe) else $error("outputs not enabled");
    a_tick_period: assert property (programmerPortBitTick && tickSeen
        |-> tickGap == BIT_CYCLES - 1) else $error("bit tick period wrong");
    c_read: cover property (busAck && !reqPrev.write);
    c_stop: cover property ($rose(systemStop));
    c_jumper: cover property ($fell(busGrantOe));
endmodule

bind cfr_top cfr_top_checker #(
    .LOCK_CYCLES(LOCK_CYCLES), .BIT_CYCLES(BIT_CYCLES)
) chk_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .busReq(busReq),
    .busRdata(busRdata), .busAck(busAck), .cpuSig(cpuSig),
    .jumperClosed(jumperClosed), .busGrant(busGrant),
    .busGrantOe(busGrantOe), .systemStop(systemStop),
    .systemStopOe(systemStopOe), .faultFlags(faultFlags),
    .pageActive(pageActive), .pageIndex(pageIndex),
    .programmerPortBitTick(programmerPortBitTick)
);

// >>> tb/cfr_cpu_model.sv
// Model of the CPU modules contending for the backplane.
// Assumes the bench says which CPUs want the bus and want to lock it.
`timescale 1ns/1ns
module cfr_cpu_model (
    input  wire logic               sys_clk,  // System clock
    input  wire logic               rst_b,    // Reset, active low
    input  wire logic [3:0]         wantBus,  // CPUs asking for the bus
    input  wire logic [3:0]         wantLock, // CPUs wanting to lock
    input  wire logic [3:0]         busGrant, // Grants from the block
    output cfr_pkg::cfr_cpu_sig_type cpuSig   // Request and lock lines
);
    // Lock only on a grant already held, as a real CPU does
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpuSig <= '0;
        end else begin
            cpuSig.request <= wantBus;
            cpuSig.lock    <= wantLock & busGrant;
        end
    end
endmodule

// >>> tb/cfr_top_test.sv
// Self-checking bench for cfr_top with a CPU model on the backplane.
// Assumes short lock and bit counts so the run stays brief.
`timescale 1ns/1ns
module cfr_top_test;
    localparam int LOCK = 20;
    logic                     sys_clk = 1'h0;
    logic                     rst_b = 1'h0;
    logic                     jumperClosed = 1'h1;
    logic                     clkEn = 1'h1;
    logic [3:0]               wantBus = 4'h0;
    logic [3:0]               wantLock = 4'h0;
    cfr_pkg::cfr_bus_req_type busReq = '0;
    cfr_pkg::cfr_cpu_sig_type cpuSig;
    logic [7:0]               busRdata, faultFlags, rd;
    logic [3:0]               busGrant;
    logic [1:0]               pageIndex;
    logic                     busAck, busGrantOe, systemStop, systemStopOe;
    logic                     pageActive, tick, ack;
    int                       num_errors = 0;
    int                       total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    cfr_top #(.LOCK_CYCLES(LOCK), .BIT_CYCLES(8)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .busReq(busReq),
        .busRdata(busRdata), .busAck(busAck), .cpuSig(cpuSig),
        .jumperClosed(jumperClosed), .busGrant(busGrant),
        .busGrantOe(busGrantOe), .systemStop(systemStop),
        .systemStopOe(systemStopOe), .faultFlags(faultFlags),
        .pageActive(pageActive), .pageIndex(pageIndex),
        .programmerPortBitTick(tick));
    cfr_cpu_model cpu_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .wantBus(wantBus), .wantLock(wantLock), .busGrant(busGrant),
        .cpuSig(cpuSig));
    task check(input string name, input logic [7:0] exp, seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Strobe held until ack or for five cycles without one, then dropped at that same edge
    task access(input logic [19:0] a, input logic ext, wr,
                input logic [7:0] d);
        ack = 1'h0;
        @(posedge sys_clk);
        busReq <= '{addr: a, extended: ext, read: !wr, write: wr, wdata: d};
        for (int i = 0; i < 5 && !ack; i++) begin
            @(posedge sys_clk);
            if (busAck === 1'h1) begin
                ack = 1'h1;
                rd = busRdata;
            end
        end
        busReq.read <= 1'h0;
        busReq.write <= 1'h0;
    endtask
    task t_reset;
        check("page", 8'h00, {5'h0, pageActive, pageIndex});
        check("oe", 8'h03, {6'h0, busGrantOe, systemStopOe});
        $display("t_reset done");
    endtask
    task t_pages;
        logic [7:0] ids [5] = '{8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h00};
        logic [7:0] pg;
        foreach (ids[i]) begin
            access(i[0] ? 20'hFFEFF : 20'hAFEFF, i[0], 1'h1, ids[i]);
            check("wr ack", 8'h01, {7'h0, ack});
            pg = {5'h0, ids[i] >= 8'hFC, ids[i][1:0]};
            check("page", pg, {5'h0, pageActive, pageIndex});
            access(20'h0FEFF, 1'h0, 1'h0, 8'h00);
            check("read", 8'h00, rd);
        end
        $display("t_pages done");
    endtask
    task t_unmapped;
        access(20'h0FEFE, 1'h0, 1'h1, 8'hFD);
        check("ack", 8'h00, {7'h0, ack});
        access(20'h0FEFF, 1'h1, 1'h1, 8'hFD);
        check("ack ext", 8'h00, {7'h0, ack});
        check("page", 8'h00, {5'h0, pageActive, pageIndex});
        $display("t_unmapped done");
    endtask
    task t_lock;
        int n;
        @(posedge sys_clk);
        wantBus <= 4'h4;
        wantLock <= 4'h4;
        for (n = 0; n < LOCK + 20 && systemStop !== 1'h1; n++)
            @(posedge sys_clk);
        check("stop", 8'h01, {7'h0, systemStop});
        check("flags", 8'h04, faultFlags);
        access(20'h0FEFF, 1'h0, 1'h0, 8'h00);
        check("read", 8'h04, rd);
        access(20'hFFEFF, 1'h1, 1'h1, 8'h00);
        check("kept", 8'h04, faultFlags);
        @(posedge sys_clk);
        wantLock <= 4'h0;
        wantBus <= 4'h0;
        for (n = 0; n < 10 && systemStop !== 1'h0; n++) @(posedge sys_clk);
        check("cleared", 8'h00, faultFlags);
        $display("t_lock done");
    endtask
    task t_jumper;
        @(posedge sys_clk);
        jumperClosed <= 1'h0;
        wantBus <= 4'h2;
        repeat (4) @(posedge sys_clk);
        check("off", 8'h00, {2'h0, busGrant, busGrantOe, systemStopOe});
        jumperClosed <= 1'h1;
        repeat (3) @(posedge sys_clk);
        check("on", 8'h0B, {2'h0, busGrant, busGrantOe, systemStopOe});
        wantBus <= 4'h0;
        $display("t_jumper done");
    endtask
    // A low enable must freeze the bus decode and the bit clock alike
    task t_freeze;
        logic t;
        @(posedge sys_clk);
        clkEn <= 1'h0;
        @(posedge sys_clk);
        t = tick;
        access(20'h0FEFF, 1'h0, 1'h1, 8'hFD);
        check("frozen ack", 8'h00, {7'h0, ack});
        check("frozen page", 8'h00, {5'h0, pageActive, pageIndex});
        check("frozen tick", {7'h0, t}, {7'h0, tick});
        clkEn <= 1'h1;
        $display("t_freeze done");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge sys_clk);
        t_reset;
        t_pages;
        t_unmapped;
        t_lock;
        t_jumper;
        t_freeze;
        repeat (20) @(posedge sys_clk);
        end_sim;
    end
    // The scenarios need well under two hundred cycles; this leaves a wide margin
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        end_sim;
    end
endmodule
